//--- tsw_pkg.sv
/*
 * Package of the transmit status writeback block: register map, status word
 * layout, operating mode fields and the carrier structs of its ports.
 * Assumes one clock domain and an AXI4-Lite master with 32-bit data.
 */
package tsw_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OPMODE = 8'h00;
    localparam logic [7:0] OFF_IRQ = 8'h04;
    localparam logic [7:0] OFF_LAST = 8'h08;
    // Status word bit positions
    localparam int BIT_OWN = 31;
    localparam int BIT_ERR_SUM = 15;
    localparam int BIT_JABBER = 14;
    localparam int BIT_CARR_DROP = 11;
    localparam int BIT_NO_CARR = 10;
    localparam int BIT_LATE_COLL = 9;
    localparam int BIT_EXCESS_COLL = 8;
    localparam int BIT_HEARTBEAT = 7;
    localparam int COLL_CNT_LSB = 3;
    localparam int BIT_LINK_FAIL = 2;
    localparam int BIT_UNDERFLOW = 1;
    localparam int BIT_CARR_WAIT = 0;
    // Operating mode fields
    localparam int OPM_10M = 0;
    localparam int OPM_LB_LSB = 10;
    localparam int OPM_SYM = 23;
    localparam logic [1:0] LB_INTERNAL = 2'h1;
    localparam logic [31:0] OPMODE_RST = 32'h0000_0000;
    // Interrupt status bit positions
    localparam int IRQ_TI = 0;
    localparam int IRQ_TJT = 3;
    localparam int IRQ_UNF = 5;
    // Collision limits and AXI response codes
    localparam logic [6:0] COLL_WINDOW_BYTES = 7'h40;
    localparam logic [4:0] MAX_COLL = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_WRITE = 3'h4
    } tsw_fsm_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tsw_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tsw_axi_rsp_t;

    // Events from the transmit engine, one-cycle pulses except the carrier and link_fail levels and desc_addr
    typedef struct packed {
        logic frame_start;
        logic frame_done;
        logic buf_empty;
        logic byte_sent;
        logic carrier;
        logic defer;
        logic collision;
        logic jabber;
        logic fifo_empty;
        logic heartbeat_miss;
        logic link_fail;
        logic [31:0] desc_addr;
    } tsw_tx_ev_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } tsw_wb_t;
endpackage

//--- tsw_status_wb.sv
/*
 * Transmit status word writeback: gathers frame events into the first
 * descriptor word and writes it to host memory with ownership returned.
 * Assumes the transmit engine and memory port share core_clk_in.
 */
// The AXI4-Lite register port and the register addresses were decided locally.
//
// Function
// - Ownership bit 31 cleared on completion
// - Error summary ORs the six error bits
// - Jabber sets bit 14, irq, abort, stop
// - Jabber timeout invalidates heartbeat fail
// - Carrier lost during frame sets bit 11
// - Carrier absent during frame sets bit 10
// - Carrier bits invalid in internal loopback
// - Late collision aborts, sets bit 9 unless underflow
// - Sixteen collisions abort and set bit 8
// - Heartbeat miss at 10 Mb/s sets 7
// - Underflow invalidates heartbeat fail
// - Retry after collision skips heartbeat check
// - Bits 6 to 3 count collisions
// - Count invalid with excessive collisions
// - Link fail bit 2 in symbol mode
// - Underflow aborts, suspends, sets two irqs
// - Deferral for carrier sets bit 0
// - Status word at aligned descriptor start
`timescale 1ns/1ps
module tsw_status_wb
    import tsw_pkg::*;
(
    input wire logic core_clk_in, // 250 MHz clock
    input wire logic resetn_in, // Async reset, active low
    input wire tsw_axi_req_t axi_req_in, // AXI4-Lite requests
    output tsw_axi_rsp_t axi_rsp_out, // AXI4-Lite answers
    input wire tsw_tx_ev_t tx_ev_in, // Transmit engine events
    output tsw_wb_t wb_out, // Descriptor status write
    input wire logic wb_ready_in, // Memory takes the write
    output logic tx_abort_out, // Abort frame pulse
    output logic tx_stop_out, // Enter stopped pulse
    output logic tx_suspend_out // Enter suspended pulse
);
    typedef struct packed {
        tsw_fsm_t fsm;
        logic [31:0] opmode;
        logic irq_ti, irq_tjt, irq_unf;
        logic [31:0] last;
        logic jab, cdrop, nocarr, late, excess, hbfail, lnkfail, undfl, cwait;
        logic seen_carrier, retry, more;
        logic [4:0] coll;
        logic [6:0] bytes;
        logic aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        tsw_axi_rsp_t rsp;
        tsw_wb_t wb;
        logic abort, stop, suspend;
    } tsw_state_t;

    tsw_state_t s;
    tsw_state_t next_s;
    logic lb_int;
    logic end_frame;
    logic [31:0] word;

    assign lb_int = (s.opmode[OPM_LB_LSB +: 2] == LB_INTERNAL);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.abort = 1'b0;
        next_s.stop = 1'b0;
        next_s.suspend = 1'b0;
        end_frame = 1'b0;
        word = 32'h0000_0000;
        // Register writes, address and data in either order
        if (axi_req_in.awvalid && s.rsp.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && s.rsp.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req_in.wdata;
            next_s.wstrb = axi_req_in.wstrb;
        end
        if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = RESP_OKAY;
            unique case (s.awaddr)
                OFF_OPMODE: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s.wstrb[i]) begin
                            next_s.opmode[8*i +: 8] = s.wdata[8*i +: 8];
                        end
                    end
                end
                OFF_IRQ: begin
                    // Write one to clear; a same-cycle event sets again below
                    if (s.wstrb[0]) begin
                        next_s.irq_ti = s.irq_ti & ~s.wdata[IRQ_TI];
                        next_s.irq_tjt = s.irq_tjt & ~s.wdata[IRQ_TJT];
                        next_s.irq_unf = s.irq_unf & ~s.wdata[IRQ_UNF];
                    end
                end
                OFF_LAST: ;
                default: next_s.rsp.bresp = RESP_SLVERR;
            endcase
        end
        if (s.rsp.bvalid && axi_req_in.bready) begin
            next_s.rsp.bvalid = 1'b0;
        end
        next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;
        // Register reads
        if (s.rsp.rvalid && axi_req_in.rready) begin
            next_s.rsp.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && s.rsp.arready) begin
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rresp = RESP_OKAY;
            unique case (axi_req_in.araddr)
                OFF_OPMODE: next_s.rsp.rdata = s.opmode;
                OFF_IRQ: begin
                    next_s.rsp.rdata = 32'h0000_0000;
                    next_s.rsp.rdata[IRQ_TI] = s.irq_ti;
                    next_s.rsp.rdata[IRQ_TJT] = s.irq_tjt;
                    next_s.rsp.rdata[IRQ_UNF] = s.irq_unf;
                end
                OFF_LAST: next_s.rsp.rdata = s.last;
                default: begin
                    next_s.rsp.rdata = 32'h0000_0000;
                    next_s.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;

        // ************************************************************
        // Frame status gathering
        // ************************************************************
        unique case (s.fsm)
            ST_IDLE: begin
                if (tx_ev_in.frame_start) begin
                    {next_s.jab, next_s.cdrop, next_s.nocarr, next_s.late} = 4'h0;
                    next_s.excess = 1'b0;
                    {next_s.hbfail, next_s.undfl, next_s.cwait, next_s.retry} = 4'h0;
                    next_s.seen_carrier = 1'b0;
                    next_s.coll = 5'h00;
                    next_s.bytes = 7'h00;
                    next_s.lnkfail = tx_ev_in.link_fail && s.opmode[OPM_SYM];
                    next_s.fsm = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_ev_in.byte_sent && s.bytes < COLL_WINDOW_BYTES) begin
                    next_s.bytes = s.bytes + 7'h01;
                end
                if (tx_ev_in.carrier) begin
                    next_s.seen_carrier = 1'b1;
                end else if (s.seen_carrier) begin
                    next_s.cdrop = 1'b1;
                end
                if (tx_ev_in.defer) begin
                    next_s.cwait = 1'b1;
                end
                if (tx_ev_in.collision) begin
                    if (s.bytes >= COLL_WINDOW_BYTES) begin
                        next_s.late = 1'b1;
                        end_frame = 1'b1;
                    end else begin
                        next_s.coll = s.coll + 5'h01;
                        next_s.retry = 1'b1;
                        if (next_s.coll == MAX_COLL) begin
                            next_s.excess = 1'b1;
                            end_frame = 1'b1;
                        end
                    end
                end
                if (tx_ev_in.heartbeat_miss && s.opmode[OPM_10M] && !next_s.retry) begin
                    next_s.hbfail = 1'b1;
                end
                if (tx_ev_in.jabber) begin
                    next_s.jab = 1'b1;
                    next_s.irq_tjt = 1'b1;
                    next_s.stop = 1'b1;
                    end_frame = 1'b1;
                end
                if (tx_ev_in.fifo_empty) begin
                    next_s.undfl = 1'b1;
                    next_s.irq_unf = 1'b1;
                    next_s.irq_ti = 1'b1;
                    next_s.suspend = 1'b1;
                    end_frame = 1'b1;
                end
                next_s.abort = end_frame;
                if (tx_ev_in.frame_done && !end_frame) begin
                    end_frame = 1'b1;
                end
                if (end_frame) begin
                    next_s.nocarr = !(next_s.seen_carrier);
                    word[BIT_JABBER] = next_s.jab;
                    word[BIT_CARR_DROP] = next_s.cdrop && !lb_int;
                    word[BIT_NO_CARR] = next_s.nocarr && !lb_int;
                    word[BIT_LATE_COLL] = next_s.late && !next_s.undfl;
                    word[BIT_EXCESS_COLL] = next_s.excess;
                    word[BIT_HEARTBEAT] = next_s.hbfail && !next_s.jab
                        && !next_s.undfl;
                    word[COLL_CNT_LSB +: 4] = next_s.excess ? 4'h0 : next_s.coll[3:0];
                    word[BIT_LINK_FAIL] = next_s.lnkfail;
                    word[BIT_UNDERFLOW] = next_s.undfl;
                    word[BIT_CARR_WAIT] = next_s.cwait;
                    word[BIT_ERR_SUM] = word[BIT_UNDERFLOW] | word[BIT_EXCESS_COLL]
                        | word[BIT_LATE_COLL] | word[BIT_NO_CARR] | word[BIT_CARR_DROP]
                        | word[BIT_JABBER];
                    next_s.more = 1'b0;
                end else if (tx_ev_in.buf_empty) begin
                    next_s.more = 1'b1;
                end
                if (end_frame || tx_ev_in.buf_empty) begin
                    word[BIT_OWN] = 1'b0;
                    next_s.wb.valid = 1'b1;
                    next_s.wb.data = word;
                    next_s.wb.addr = {tx_ev_in.desc_addr[31:2], 2'h0};
                    next_s.fsm = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (wb_ready_in) begin
                    next_s.wb.valid = 1'b0;
                    if (!s.more) begin
                        next_s.last = s.wb.data;
                    end
                    next_s.fsm = s.more ? ST_SEND : ST_IDLE;
                end
            end
            default: next_s.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s <= '0;
            s.fsm <= ST_IDLE;
            s.opmode <= OPMODE_RST;
            s.rsp.awready <= 1'b1;
            s.rsp.wready <= 1'b1;
            s.rsp.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign axi_rsp_out = s.rsp;
    assign wb_out = s.wb;
    assign tx_abort_out = s.abort;
    assign tx_stop_out = s.stop;
    assign tx_suspend_out = s.suspend;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    AST_OWN_CLEAR: assert property (wb_out.valid |-> !wb_out.data[BIT_OWN])
        else $error("ownership not returned");
    AST_ERR_SUM: assert property (wb_out.valid |-> wb_out.data[BIT_ERR_SUM] ==
        (wb_out.data[BIT_UNDERFLOW] | wb_out.data[BIT_EXCESS_COLL]
        | wb_out.data[BIT_LATE_COLL] | wb_out.data[BIT_NO_CARR]
        | wb_out.data[BIT_CARR_DROP] | wb_out.data[BIT_JABBER]))
        else $error("error summary mismatch");
    AST_JABBER: assert property (s.fsm == ST_SEND && tx_ev_in.jabber |=> tx_stop_out
        && tx_abort_out && wb_out.valid && wb_out.data[BIT_JABBER] && s.irq_tjt)
        else $error("jabber not handled");
    AST_HB_JABBER: assert property (wb_out.valid && wb_out.data[BIT_JABBER]
        |-> !wb_out.data[BIT_HEARTBEAT])
        else $error("heartbeat with jabber");
    AST_LOOPBACK: assert property (wb_out.valid && lb_int
        |-> !wb_out.data[BIT_CARR_DROP] && !wb_out.data[BIT_NO_CARR])
        else $error("carrier bits in loopback");
    AST_LATE: assert property (s.fsm == ST_SEND && tx_ev_in.collision
        && s.bytes >= COLL_WINDOW_BYTES && !tx_ev_in.fifo_empty
        |=> tx_abort_out && wb_out.data[BIT_LATE_COLL])
        else $error("late collision missed");
    AST_EXCESS: assert property (s.fsm == ST_SEND && tx_ev_in.collision
        && s.coll == 5'h0F && s.bytes < COLL_WINDOW_BYTES
        |=> tx_abort_out && wb_out.data[BIT_EXCESS_COLL]
        && wb_out.data[COLL_CNT_LSB +: 4] == 4'h0)
        else $error("excessive collisions missed");
    AST_HB_RETRY: assert property (wb_out.valid && s.retry
        |-> !wb_out.data[BIT_HEARTBEAT])
        else $error("heartbeat on retry");
    AST_UNDERFLOW: assert property (s.fsm == ST_SEND && tx_ev_in.fifo_empty
        |=> tx_suspend_out && wb_out.data[BIT_UNDERFLOW] && !wb_out.data[BIT_HEARTBEAT]
        && s.irq_unf && s.irq_ti)
        else $error("underflow not handled");
    AST_ALIGN: assert property (wb_out.valid |-> wb_out.addr[1:0] == 2'h0)
        else $error("unaligned descriptor");
    AST_HOLD: assert property (wb_out.valid && !wb_ready_in
        |=> wb_out.valid && $stable(wb_out.data) && $stable(wb_out.addr))
        else $error("status word changed before taken");

    COV_CLEAN: cover property (s.fsm == ST_SEND && tx_ev_in.frame_done ##1 wb_out.valid);
    COV_JABBER: cover property (tx_stop_out ##[1:8] !wb_out.valid);
    COV_RETRY: cover property (s.retry && wb_out.valid && !wb_out.data[BIT_ERR_SUM]);
    COV_BUF_EMPTY: cover property (wb_out.valid && wb_ready_in && s.more);
endmodule // tsw_status_wb

//--- tsw_host_mem.sv
/*
 * Host memory model for the status writeback port: takes status writes,
 * optionally stalling, and records the last one.
 * Assumes the writeback port of the status block on core_clk_in.
 */
`timescale 1ns/1ps
module tsw_host_mem
    import tsw_pkg::*;
(
    input wire logic core_clk_in, // Clock
    input wire logic resetn_in, // Async reset, active low
    input wire tsw_wb_t wb_in, // Status write from block
    input wire logic stall_in, // Hold off writes
    output logic wb_ready_out, // Write taken
    output logic [31:0] last_addr_out, // Address of last write
    output logic [31:0] last_data_out, // Data of last write
    output logic [15:0] wr_count_out // Writes taken
);
    // Descriptors handed out whole, never re-armed mid-frame
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_ready_out <= 1'b0;
            last_addr_out <= 32'h0;
            last_data_out <= 32'h0;
            wr_count_out <= 16'h0;
        end else begin
            wb_ready_out <= !stall_in;
            if (wb_in.valid && wb_ready_out) begin
                last_addr_out <= wb_in.addr;
                last_data_out <= wb_in.data;
                wr_count_out <= wr_count_out + 16'h1;
            end
        end
    end
endmodule // tsw_host_mem

//--- tsw_status_wb_tb_top.sv
/*
 * Testbench of the transmit status writeback block: frame events, register
 * accesses over AXI4-Lite and checks of each written status word.
 * Assumes the host memory model as the writeback partner.
 */
`timescale 1ns/1ps
module tsw_status_wb_tb_top
    import tsw_pkg::*;
;
    localparam logic [10:0] E_START = 11'h400;
    localparam logic [10:0] E_DONE = 11'h200;
    localparam logic [10:0] E_BUFE = 11'h100;
    localparam logic [10:0] E_BYTE = 11'h080;
    localparam logic [10:0] E_CARR = 11'h040;
    localparam logic [10:0] E_DEF = 11'h020;
    localparam logic [10:0] E_COLL = 11'h010;
    localparam logic [10:0] E_JAB = 11'h008;
    localparam logic [10:0] E_FIFO = 11'h004;
    localparam logic [10:0] E_HB = 11'h002;
    localparam logic [10:0] E_LINK = 11'h001;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic stall = 1'b0;
    logic wb_rdy, ab, st, su;
    tsw_axi_req_t rq = '0;
    tsw_axi_rsp_t rsp;
    tsw_tx_ev_t ev = '0;
    tsw_wb_t wb;
    logic [31:0] m_addr, m_data;
    logic [31:0] dsc = 32'h0000_2000;
    logic [15:0] m_cnt;
    logic [10:0] lvl = 11'h040;
    int bad_count = 0;
    int n_tests = 0;
    int n_ab = 0;
    int n_st = 0;
    int n_su = 0;

    always #2 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        if (ab === 1'b1) n_ab++;
        if (st === 1'b1) n_st++;
        if (su === 1'b1) n_su++;
    end

    tsw_status_wb i_tsw_status_wb (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .axi_req_in(rq), .axi_rsp_out(rsp), .tx_ev_in(ev), .wb_out(wb), .wb_ready_in(wb_rdy),
        .tx_abort_out(ab), .tx_stop_out(st), .tx_suspend_out(su));
    tsw_host_mem i_tsw_host_mem (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .wb_in(wb), .stall_in(stall), .wb_ready_out(wb_rdy), .last_addr_out(m_addr),
        .last_data_out(m_data), .wr_count_out(m_cnt));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic hang(input string nm);
        bad_count++;
        $display("CHECK FAILED %s expected answer seen timeout", nm);
        final_report();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk_in);
        rq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
            bready: 1'b1, default: '0};
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk_in);
            if (rsp.awready) rq.awvalid <= 1'b0;
            if (rsp.wready) rq.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        if (i == 100) hang("write");
        chk("write resp", {30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
        rq.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
            input string nm);
        int i;
        @(posedge core_clk_in);
        rq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk_in);
            if (rsp.arready) rq.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        if (i == 100) hang(nm);
        chk(nm, rsp.rdata, exp);
        chk("read resp", {30'h0, rsp.rresp}, {30'h0, er});
        rq.rready <= 1'b0;
    endtask

    // One event cycle, then levels only
    task automatic pulse(input logic [10:0] f);
        @(posedge core_clk_in);
        ev <= {f | lvl, dsc};
        @(posedge core_clk_in);
        ev <= {lvl, dsc};
    endtask

    task automatic run(input logic [10:0] a, input int na, input logic [10:0] b, input int nb,
            input logic [10:0] fin, input logic [31:0] exp, input logic [31:0] msk,
            input logic [2:0] pl, input string nm);
        logic [15:0] c0;
        logic [31:0] d0;
        int i, a0, s0, u0;
        c0 = m_cnt;
        d0 = m_data;
        a0 = n_ab;
        s0 = n_st;
        u0 = n_su;
        pulse(E_START);
        repeat (na) pulse(a);
        repeat (nb) pulse(b);
        pulse(fin);
        for (i = 0; i < 60 && m_cnt == c0; i++) begin
            @(posedge core_clk_in);
            if (i == 6) stall <= 1'b0;
        end
        if (m_cnt == c0) hang(nm);
        chk(nm, m_data & ~msk, exp);
        chk("status addr", m_addr, dsc);
        chk("pulses", {29'h0, n_ab != a0, n_st != s0, n_su != u0}, {29'h0, pl});
        // Buffer handback mid frame leaves the last status record alone
        rd(OFF_LAST, (fin == E_BUFE) ? d0 : m_data, RESP_OKAY, "last status");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        rd(OFF_OPMODE, OPMODE_RST, RESP_OKAY, "opmode reset");
        rd(8'h0C, 32'h0, RESP_SLVERR, "unmapped");
        wr(OFF_LAST, 32'hFFFF_FFFF);
        rd(OFF_LAST, 32'h0, RESP_OKAY, "last read only");
        wr(OFF_OPMODE, 32'h0000_0001);
        stall <= 1'b1;
        run(E_BYTE, 4, E_HB, 1, E_DONE, 32'h0000_0080, 32'h0, 3'h0, "heartbeat");
        run(E_COLL | E_DEF, 2, E_HB, 1, E_DONE, 32'h0000_0011, 32'h0, 3'h0, "retry");
        run(E_HB, 1, E_BYTE, 1, E_JAB, 32'h0000_C000, 32'h0, 3'h6, "jabber");
        rd(OFF_IRQ, 32'h0000_0008, RESP_OKAY, "irq jabber");
        run(E_HB, 1, E_BYTE, 1, E_FIFO, 32'h0000_8002, 32'h0, 3'h5, "underflow");
        rd(OFF_IRQ, 32'h0000_0029, RESP_OKAY, "irq underflow");
        wr(OFF_IRQ, 32'h0000_0029);
        rd(OFF_IRQ, 32'h0, RESP_OKAY, "irq cleared");
        wr(OFF_OPMODE, 32'h0);
        lvl = 11'h0;
        run(E_BYTE, 3, E_HB, 1, E_DONE, 32'h0000_8400, 32'h0, 3'h0,
            "no carrier");
        run(E_CARR | E_BYTE, 3, 11'h0, 0, E_DONE, 32'h0000_8800, 32'h0, 3'h0, "lost");
        wr(OFF_OPMODE, 32'h0000_0400);
        run(E_BYTE, 2, 11'h0, 0, E_DONE, 32'h0, 32'h0, 3'h0, "loopback");
        wr(OFF_OPMODE, 32'h0080_0000);
        lvl = E_CARR | E_LINK;
        run(E_BYTE, 2, 11'h0, 0, E_DONE, 32'h0000_0004, 32'h0, 3'h0, "link fail");
        wr(OFF_OPMODE, 32'h0);
        run(E_BYTE, 63, E_COLL, 1, E_DONE, 32'h0000_0008, 32'h0, 3'h0,
            "early");
        lvl = E_CARR;
        run(E_BYTE, 65, 11'h0, 0, E_COLL, 32'h0000_8200, 32'h78, 3'h4, "late");
        run(E_COLL, 15, 11'h0, 0, E_DONE, 32'h0000_0078, 32'h0, 3'h0, "count 15");
        run(E_COLL, 15, 11'h0, 0, E_COLL, 32'h0000_8100, 32'h78, 3'h4, "excess");
        stall <= 1'b1;
        run(E_BYTE, 2, 11'h0, 0, E_BUFE, 32'h0, 32'h0, 3'h0, "buffers empty");
        dsc = 32'h0000_2010;
        run(E_BYTE, 1, 11'h0, 0, E_DONE, 32'h0, 32'h0, 3'h0, "frame end");
        final_report();
    end
endmodule // tsw_status_wb_tb_top
